// [lgc_pkg.sv]
// constants and types for the loudness pin control block
package lgc_pkg;
    // =====================================================
    // timing
    localparam int CLK_MHZ        = 250;
    localparam int DEBOUNCE_NS    = 1000;
    localparam int DEBOUNCE_CYC   = (DEBOUNCE_NS * CLK_MHZ + 999) / 1000;
    localparam int PULSE_MS       = 100;
    localparam int PULSE_CYC      = PULSE_MS * CLK_MHZ * 1000;
    // pulse window accepted around the nominal length
    localparam int PULSE_MIN_CYC  = PULSE_CYC / 2;
    localparam int PULSE_MAX_CYC  = PULSE_CYC + PULSE_CYC / 2;
    localparam int CNT_W          = 26;
    localparam int DB_W           = 9;
    // =====================================================
    // pins and states
    localparam int PIN_N          = 4;
    localparam int METER_N        = 2;
    localparam int SEL_LOW_PAIR   = 0;
    typedef enum logic [1:0] {
        ST_RESET,
        ST_RUN,
        ST_PAUSE
    } lgc_state_t;
    // state report codes, one-hot
    localparam logic [2:0] REP_RESET = 3'h1;
    localparam logic [2:0] REP_RUN   = 3'h2;
    localparam logic [2:0] REP_PAUSE = 3'h4;
endpackage

// [lgc_meter.sv]
// per-meter pin decode and run/pause/reset state machine
`timescale 1ns/1ps
module lgc_meter #(
    parameter int PULSE_MIN = lgc_pkg::PULSE_MIN_CYC,
    parameter int PULSE_MAX = lgc_pkg::PULSE_MAX_CYC
) (
    input  wire logic                      ref_clk_i,
    input  wire logic                      rst_b_i,
    input  wire logic                      clk_en_i,
    input  wire logic [lgc_pkg::PIN_N-1:0] pins_i,
    input  wire logic                      pair_sel_i,
    input  wire logic                      ext_en_i,
    input  wire logic                      run_high_i,
    input  wire logic                      log_en_i,
    input  wire logic                      man_start_i,
    input  wire logic                      man_pause_i,
    input  wire logic                      man_reset_i,
    output logic [2:0]                     external_control_state_report_o,
    output logic                           meter_run_o,
    output logic                           integ_clear_o,
    output logic                           new_log_o
);
    // =====================================================
    // pair selection
    wire logic hc_pin = pair_sel_i ? pins_i[2] : pins_i[0];
    wire logic gh_pin = pair_sel_i ? pins_i[3] : pins_i[1];
    // run level after polarity
    wire logic go_raw = run_high_i ? gh_pin : ~gh_pin;

    logic                          hc_reg;
    logic                          go_reg;
    logic                          go_prev_reg;
    logic [lgc_pkg::CNT_W-1:0]     low_cnt_reg;
    lgc_pkg::lgc_state_t           state_reg;
    lgc_pkg::lgc_state_t           state_next;

    // =====================================================
    // decode
    wire logic pulse_end = go_reg & ~go_prev_reg
        & (low_cnt_reg >= lgc_pkg::CNT_W'(PULSE_MIN))
        & (low_cnt_reg <= lgc_pkg::CNT_W'(PULSE_MAX));

    always_comb begin
        state_next = state_reg;
        if (ext_en_i) begin
            if (hc_reg) begin
                state_next = lgc_pkg::ST_RESET;
            end else if (go_reg) begin
                state_next = lgc_pkg::ST_RUN;
            end else begin
                state_next = lgc_pkg::ST_PAUSE;
            end
        end else begin
            // manual commands only without pin control
            if (man_reset_i) begin
                state_next = lgc_pkg::ST_RESET;
            end else if (man_pause_i && state_reg == lgc_pkg::ST_RUN) begin
                state_next = lgc_pkg::ST_PAUSE;
            end else if (man_start_i) begin
                state_next = lgc_pkg::ST_RUN;
            end
        end
    end

    // every pause-to-run resume logs via start_ev, inside or outside the restart pulse window
    // go-hold rising while hold-clear is high must not log a restart
    wire logic is_restart = ext_en_i & pulse_end
        & (state_reg == lgc_pkg::ST_PAUSE)
        & (state_next == lgc_pkg::ST_RUN);
    wire logic start_ev = (state_next == lgc_pkg::ST_RUN)
        & (state_reg != lgc_pkg::ST_RUN);

    // =====================================================
    // state
    always_ff @(posedge ref_clk_i) begin
        if (!rst_b_i) begin
            hc_reg      <= 1'b1;
            go_reg      <= 1'b1;
            go_prev_reg <= 1'b1;
            low_cnt_reg <= '0;
            state_reg   <= lgc_pkg::ST_RESET;
            integ_clear_o <= 1'b1;
            new_log_o   <= 1'b0;
        end else if (clk_en_i) begin
            hc_reg      <= hc_pin;
            go_reg      <= go_raw;
            go_prev_reg <= go_reg;
            if (go_reg) begin
                low_cnt_reg <= '0;
            end else if (low_cnt_reg != '1) begin
                low_cnt_reg <= low_cnt_reg + 1'b1;
            end
            state_reg <= state_next;
            integ_clear_o <= (state_next == lgc_pkg::ST_RESET);
            new_log_o <= log_en_i & start_ev;
            if (is_restart) begin
                new_log_o <= log_en_i;
            end
        end
    end

    always_comb begin
        unique case (state_reg)
            lgc_pkg::ST_RUN:   external_control_state_report_o = lgc_pkg::REP_RUN;
            lgc_pkg::ST_PAUSE: external_control_state_report_o = lgc_pkg::REP_PAUSE;
            default:           external_control_state_report_o = lgc_pkg::REP_RESET;
        endcase
    end
    assign meter_run_o = (state_reg == lgc_pkg::ST_RUN);
endmodule

// [lgc_top.sv]
// loudness pin control: synchroniser, debounce, two meters, conflict flag
`timescale 1ns/1ps
module lgc_top #(
    parameter int PULSE_MIN = lgc_pkg::PULSE_MIN_CYC,
    parameter int PULSE_MAX = lgc_pkg::PULSE_MAX_CYC
) (
    input  wire logic                        ref_clk_i,
    input  wire logic                        rst_b_i,
    input  wire logic                        clk_en_i,
    input  wire logic [lgc_pkg::PIN_N-1:0]   pins_i,
    input  wire logic [lgc_pkg::METER_N-1:0] pair_sel_i,
    input  wire logic [lgc_pkg::METER_N-1:0] ext_en_i,
    input  wire logic                        run_high_i,
    input  wire logic [lgc_pkg::METER_N-1:0] log_en_i,
    input  wire logic [lgc_pkg::METER_N-1:0] man_start_i,
    input  wire logic [lgc_pkg::METER_N-1:0] man_pause_i,
    input  wire logic [lgc_pkg::METER_N-1:0] man_reset_i,
    input  wire logic [lgc_pkg::PIN_N-1:0]   preset_pin_en_i,
    output logic [3*lgc_pkg::METER_N-1:0]    external_control_state_report_o,
    output logic [lgc_pkg::METER_N-1:0]      meter_run_o,
    output logic [lgc_pkg::METER_N-1:0]      integ_clear_o,
    output logic [lgc_pkg::METER_N-1:0]      new_log_o,
    output logic                             config_error_o
);
    // =====================================================
    // pin conditioning
    logic [lgc_pkg::PIN_N-1:0] sync1_reg;
    logic [lgc_pkg::PIN_N-1:0] sync2_reg;
    logic [lgc_pkg::PIN_N-1:0] clean_reg;
    logic [lgc_pkg::DB_W-1:0]  db_cnt_reg;

    // idle-high pins so power-on decodes as reset
    always_ff @(posedge ref_clk_i) begin
        if (!rst_b_i) begin
            sync1_reg  <= '1;
            sync2_reg  <= '1;
            clean_reg  <= '1;
            db_cnt_reg <= '0;
        end else if (clk_en_i) begin
            sync1_reg <= pins_i;
            sync2_reg <= sync1_reg;
            if (sync2_reg == clean_reg) begin
                db_cnt_reg <= '0;
            end else if (db_cnt_reg ==
                         lgc_pkg::DB_W'(lgc_pkg::DEBOUNCE_CYC - 1)) begin
                clean_reg  <= sync2_reg;
                db_cnt_reg <= '0;
            end else begin
                db_cnt_reg <= db_cnt_reg + 1'b1;
            end
        end
    end

    // =====================================================
    // conflict: preset use of any pin a live meter pair uses
    function automatic logic [lgc_pkg::PIN_N-1:0] pair_mask(input logic sel,
                                                            input logic en);
        pair_mask = en ? (sel ? 4'hc : 4'h3) : 4'h0;
    endfunction
    wire logic [lgc_pkg::PIN_N-1:0] used =
        pair_mask(pair_sel_i[0], ext_en_i[0])
        | pair_mask(pair_sel_i[1], ext_en_i[1]);

    always_ff @(posedge ref_clk_i) begin
        if (!rst_b_i) begin
            config_error_o <= 1'b0;
        end else if (clk_en_i) begin
            config_error_o <= |(used & preset_pin_en_i);
        end
    end

    // =====================================================
    // meters
    genvar m;
    generate
        for (m = 0; m < lgc_pkg::METER_N; m++) begin : g_m
            lgc_meter #(
                .PULSE_MIN (PULSE_MIN),
                .PULSE_MAX (PULSE_MAX)
            ) u_meter (
                .ref_clk_i                       (ref_clk_i),
                .rst_b_i                         (rst_b_i),
                .clk_en_i                        (clk_en_i),
                .pins_i                          (clean_reg),
                .pair_sel_i                      (pair_sel_i[m]),
                .ext_en_i                        (ext_en_i[m]),
                .run_high_i                      (run_high_i),
                .log_en_i                        (log_en_i[m]),
                .man_start_i                     (man_start_i[m]),
                .man_pause_i                     (man_pause_i[m]),
                .man_reset_i                     (man_reset_i[m]),
                .external_control_state_report_o
                    (external_control_state_report_o[3*m +: 3]),
                .meter_run_o                     (meter_run_o[m]),
                .integ_clear_o                   (integ_clear_o[m]),
                .new_log_o                       (new_log_o[m])
            );
        end
    endgenerate
endmodule

// [lgc_monitor.sv]
// checker for the loudness pin control block
`timescale 1ns/1ps
module lgc_monitor (
    input wire logic       ref_clk_i,
    input wire logic       rst_b_i,
    input wire logic [3:0] pins_i,
    input wire logic [1:0] pair_sel_i,
    input wire logic [1:0] ext_en_i,
    input wire logic [1:0] man_reset_i,
    input wire logic [3:0] preset_pin_en_i,
    input wire logic [5:0] external_control_state_report_o,
    input wire logic [1:0] meter_run_o,
    input wire logic [1:0] integ_clear_o,
    input wire logic [1:0] new_log_o,
    input wire logic       config_error_o
);
    // =====================================================
    // helpers
    wire [5:0] rep = external_control_state_report_o;
    wire [3:0] pair0 = pair_sel_i[0] ? 4'hc : 4'h3;
    wire [3:0] pair1 = pair_sel_i[1] ? 4'hc : 4'h3;
    wire conflict = (ext_en_i[0] && |(preset_pin_en_i & pair0))
                 || (ext_en_i[1] && |(preset_pin_en_i & pair1));
    wire hc0 = pair_sel_i[0] ? pins_i[2] : pins_i[0];
    // 300 covers sync, debounce and a bouncing contact
    logic [8:0] hc_cnt_reg;
    always_ff @(posedge ref_clk_i) begin
        if (!rst_b_i || !(ext_en_i[0] && hc0)) hc_cnt_reg <= 9'h0;
        else if (hc_cnt_reg != 9'h1ff) hc_cnt_reg <= hc_cnt_reg + 9'h1;
    end
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!rst_b_i);
    // =====================================================
    // assertions
    power_on_a: assert property ($rose(rst_b_i) |-> rep == 6'h09)
        else $error("state not reset after reset");
    one_state_a: assert property (
        $onehot(rep[2:0]) && $onehot(rep[5:3]))
        else $error("state report not one-hot");
    run_flag_a: assert property (
        meter_run_o[0] == (rep[2:0] == 3'h2))
        else $error("run flag disagrees with report");
    hold_reset_a: assert property (
        hc_cnt_reg >= 9'h12c |-> rep[2:0] == 3'h1)
        else $error("not in reset while hold-clear high");
    clear_reset_a: assert property (
        rep[2:0] == 3'h1 |-> integ_clear_o[0])
        else $error("integration not cleared in reset");
    resume_keep_a: assert property (
        rep[2:0] == 3'h4 ##1 rep[2:0] == 3'h2
        |-> !integ_clear_o[0] && !$past(integ_clear_o[0]))
        else $error("resume cleared integration");
    log_pulse_a: assert property (new_log_o[0] |=> !new_log_o[0])
        else $error("new log longer than one cycle");
    log_run_a: assert property (
        new_log_o[0] |-> ##[0:1] meter_run_o[0])
        else $error("new log outside running");
    config_err_a: assert property (
        1'b1 |=> config_error_o == $past(conflict))
        else $error("config error flag wrong");
    man_reset_a: assert property (
        !ext_en_i[0] && man_reset_i[0] |-> ##[1:4] rep[2:0] == 3'h1)
        else $error("manual reset ignored");
    cover property (new_log_o[0]);
    cover property (rep[2:0] == 3'h4);
    cover property (config_error_o);
endmodule

// [lgc_switch.sv]
// far-side contact model: bouncing switches with pull-ups
`timescale 1ns/1ps
module lgc_switch (
    input  wire logic       ref_clk_i,
    input  wire logic [3:0] close_i,
    output logic      [3:0] pins_o
);
    logic [3:0] last_reg   = 4'h0;
    logic [3:0] chg_reg    = 4'h0;
    logic [2:0] bounce_reg = 3'h0;
    always_ff @(posedge ref_clk_i) begin
        last_reg <= close_i;
        if (close_i != last_reg) begin
            chg_reg    <= close_i ^ last_reg;
            bounce_reg <= 3'h5;
        end else if (bounce_reg != 3'h0) begin
            bounce_reg <= bounce_reg - 3'h1;
        end
    end
    // only moved contacts chatter; open pulled up, closed grounds
    assign pins_o = ~last_reg ^ ({4{bounce_reg[0]}} & chg_reg);
endmodule

// [testbench.sv]
// self-checking bench for the loudness pin control block
`timescale 1ns/1ps
module testbench;
    logic ref_clk_i = 1'b0, rst_b_i = 1'b0, run_high = 1'b1;
    logic [3:0] close = 4'h0, pins, preset = 4'h0;
    logic [1:0] sel = 2'h0, ext = 2'h1, log_en = 2'h1;
    logic [1:0] start = 2'h0, pause = 2'h0, mreset = 2'h0;
    logic [5:0] rep, logs;
    logic [1:0] run, clr, nlog;
    logic       cfg_err;
    int miscompares = 0, compares = 0;
    always #2 ref_clk_i = ~ref_clk_i;
    lgc_switch sw (.ref_clk_i(ref_clk_i), .close_i(close), .pins_o(pins));
    lgc_top #(.PULSE_MIN(300), .PULSE_MAX(900)) dut (
        .ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i), .clk_en_i(1'b1),
        .pins_i(pins), .pair_sel_i(sel), .ext_en_i(ext),
        .run_high_i(run_high), .log_en_i(log_en), .man_start_i(start),
        .man_pause_i(pause), .man_reset_i(mreset),
        .preset_pin_en_i(preset), .external_control_state_report_o(rep),
        .meter_run_o(run), .integ_clear_o(clr), .new_log_o(nlog),
        .config_error_o(cfg_err));
    // =====================================================
    // shared tasks
    task automatic final_report();
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    task automatic chk(input logic [8:0] got, exp);
        compares++;
        if (got !== exp) begin
            miscompares++;
            $display("Error %0t got %h want %h", $time, got, exp);
        end
    endtask
    task automatic steps(input int k);
        repeat (k) begin
            @(posedge ref_clk_i);
            #1;
            if (nlog[0] === 1'b1) logs++;
        end
    endtask
    task automatic drive(input logic [3:0] c);
        @(posedge ref_clk_i);
        close <= c;
        logs = 6'h0;
    endtask
    task automatic wait_rep(input int m, input logic [2:0] exp);
        int n;
        n = 0;
        // first look one edge later, never in the launching time step
        do begin
            steps(1);
            n++;
        end while (rep[3*m +: 3] !== exp && n < 800);
        if (rep[3*m +: 3] !== exp) begin
            miscompares++;
            $display("Error %0t state wait timed out", $time);
            final_report();
        end else begin
            steps(3);
        end
    endtask
    // cmd bits: reset, pause, start of meter 0
    task automatic pulse(input logic [2:0] cmd);
        @(posedge ref_clk_i);
        {mreset[0], pause[0], start[0]} <= cmd;
        @(posedge ref_clk_i);
        {mreset[0], pause[0], start[0]} <= 3'h0;
        steps(4);
    endtask
    // =====================================================
    // scenarios
    task automatic t_pins();
        drive(4'h1);
        wait_rep(0, 3'h2);
        chk(logs, 6'h1);
        drive(4'h3);
        wait_rep(0, 3'h4);
        chk({rep[2:0], logs}, {3'h4, 6'h0});
        drive(4'h1);
        wait_rep(0, 3'h2);
        chk(logs, 6'h1);
        drive(4'h3);
        steps(600);
        chk(rep[2:0], 3'h4);
        drive(4'h1);
        wait_rep(0, 3'h2);
        chk(logs, 6'h1);
        drive(4'h0);
        wait_rep(0, 3'h1);
        chk(clr[0], 1'b1);
        drive(4'h2);
        steps(400);
        chk(rep[2:0], 3'h1);
        $display("pin control done");
    endtask
    task automatic t_pair();
        drive(4'h4);
        ext <= 2'h3;
        sel <= 2'h2;
        wait_rep(1, 3'h2);
        chk(rep[2:0], 3'h1);
        @(posedge ref_clk_i);
        sel <= 2'h3;
        wait_rep(0, 3'h2);
        chk(rep, 6'h12);
        drive(4'hc);
        wait_rep(1, 3'h4);
        chk(rep, 6'h24);
        // inverted polarity: go-hold low now means run
        @(posedge ref_clk_i);
        run_high <= 1'b0;
        wait_rep(1, 3'h2);
        chk(run, 2'h3);
        drive(4'h0);
        run_high <= 1'b1;
        wait_rep(1, 3'h1);
        $display("pair select done");
    endtask
    task automatic t_manual();
        @(posedge ref_clk_i);
        ext <= 2'h0;
        pulse(3'h1);
        chk(rep[2:0], 3'h2);
        pulse(3'h2);
        chk(rep[2:0], 3'h4);
        pulse(3'h4);
        chk(rep[2:0], 3'h1);
        @(posedge ref_clk_i);
        ext <= 2'h1;
        sel <= 2'h0;
        pulse(3'h1);
        chk(rep[2:0], 3'h1);
        @(posedge ref_clk_i);
        preset <= 4'h2;
        steps(3);
        chk(cfg_err, 1'b1);
        @(posedge ref_clk_i);
        preset <= 4'h8;
        steps(3);
        chk(cfg_err, 1'b0);
        $display("manual and conflict done");
    endtask
    initial begin
        repeat (20) @(posedge ref_clk_i);
        rst_b_i <= 1'b1;
        steps(2);
        chk({rep, cfg_err}, {6'h09, 1'b0});
        t_pins();
        t_pair();
        t_manual();
        final_report();
    end
endmodule
bind lgc_top lgc_monitor u_mon (
    .ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i), .pins_i(pins_i),
    .pair_sel_i(pair_sel_i), .ext_en_i(ext_en_i),
    .man_reset_i(man_reset_i), .preset_pin_en_i(preset_pin_en_i),
    .external_control_state_report_o(external_control_state_report_o),
    .meter_run_o(meter_run_o), .integ_clear_o(integ_clear_o),
    .new_log_o(new_log_o), .config_error_o(config_error_o));
